// ===== logic/mba_pkg.sv
package mba_pkg;

  // register byte offsets
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] GRANTS_OFFSET = 4'h8;
  localparam int         ADDR_WIDTH    = 4;
  localparam int         DATA_WIDTH    = 32;

  // control register fields
  localparam int CTRL_SW_REQUEST = 0;
  localparam int CTRL_HOLD_OFF   = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // status register fields
  localparam int STAT_OWNS       = 0;
  localparam int STAT_REQUESTING = 1;
  localparam int STAT_BUSY       = 2;
  localparam int STAT_PRIORITY   = 3;
  localparam int STAT_SHARED_REQ = 4;
  localparam int STAT_INIT       = 5;
  localparam int STAT_WIDTH      = 6;

  localparam logic [15:0] GRANTS_RESET = 16'h0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // synchronised pin positions
  localparam int PIN_BUS_CLK      = 0;
  localparam int PIN_INIT_N       = 1;
  localparam int PIN_PRIORITY_N   = 2;
  localparam int PIN_BUSY_N       = 3;
  localparam int PIN_SHARED_REQ_N = 4;
  localparam int PIN_SELECT       = 5;
  localparam int PIN_LOCAL_STRAP  = 6;
  localparam int PIN_ANY_STRAP    = 7;
  localparam int PIN_HOLD_N       = 8;
  localparam int PIN_LOCK_N       = 9;
  localparam int PIN_CYCLE        = 10;
  localparam int PIN_COUNT        = 11;

  // idle levels of the synchroniser, chosen so that nothing is requested
  localparam logic [10:0] PIN_IDLE = 11'h31E;

  typedef enum logic [1:0] {
    MBA_IDLE,
    MBA_WAIT,
    MBA_OWN
  } mba_state_t;

endpackage

// ===== logic/mba_sync.sv
`timescale 1ns/10ps
module mba_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [10:0] IDLE_LVL  = 11'h000
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // stage1 is read only by the second flop
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        next_stage1[i]   = async_in[i];
        next_sync_out[i] = stage1[i];
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stage1[i]   <= IDLE_LVL[i];
          sync_out[i] <= IDLE_LVL[i];
        end else begin
          stage1[i]   <= next_stage1[i];
          sync_out[i] <= next_sync_out[i];
        end
      end
    end
  endgenerate

endmodule

// ===== logic/mba_arbiter.sv
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// - float bus drivers unless this master owns bus
// - select input matters only with local strap high
// - local mode: select high requests, low permits surrender
// - shared request means lower-priority arbiter wants bus
// - shared request is wired open-collector, any pulls low
// - owner never pulls shared request low itself
// - on surrender drop request output, release bus
// - shared low, any-strap high: surrender each cycle end
// - init low resets arbiter; nobody owns bus
// - bus signals follow bus clock, not processor
// - request output driven low to request bus
// - priority in low lets bus be taken next falling edge
// - priority in high means priority lost upward
// - priority out feeds next lower arbiter's priority in
// - busy line free: top requester seizes, pulls low
// - lock low forbids any surrender
// - hold low forbids surrender to shared request
// - local strap low ignores select input
module mba_arbiter (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [mba_pkg::ADDR_WIDTH-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                       s_axi_awprot,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [mba_pkg::DATA_WIDTH-1:0]   s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [mba_pkg::ADDR_WIDTH-1:0]   s_axi_araddr,
  input  wire logic [2:0]                       s_axi_arprot,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [mba_pkg::DATA_WIDTH-1:0]        s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic                             bus_clk,
  input  wire logic                             init_n,
  input  wire logic                             priority_in_n,
  output logic                                  priority_out_n,
  output logic                                  arb_request_out_n,
  input  wire logic                             busy_n_i,
  output logic                                  busy_n_o,
  output logic                                  busy_n_oe_n,
  input  wire logic                             shared_request_line_n_i,
  output logic                                  shared_request_line_n_o,
  output logic                                  shared_request_line_n_oe_n,
  input  wire logic                             system_or_local_select,
  input  wire logic                             local_bus_strap,
  input  wire logic                             surrender_to_any_strap,
  input  wire logic                             shared_request_hold_n,
  input  wire logic                             lock_n,
  input  wire logic                             proc_cycle_active,
  output logic                                  bus_driver_float
);

  logic [mba_pkg::PIN_COUNT-1:0] pins_raw;
  logic [mba_pkg::PIN_COUNT-1:0] pins;

  assign pins_raw[mba_pkg::PIN_BUS_CLK]      = bus_clk;
  assign pins_raw[mba_pkg::PIN_INIT_N]       = init_n;
  assign pins_raw[mba_pkg::PIN_PRIORITY_N]   = priority_in_n;
  assign pins_raw[mba_pkg::PIN_BUSY_N]       = busy_n_i;
  assign pins_raw[mba_pkg::PIN_SHARED_REQ_N] = shared_request_line_n_i;
  assign pins_raw[mba_pkg::PIN_SELECT]       = system_or_local_select;
  assign pins_raw[mba_pkg::PIN_LOCAL_STRAP]  = local_bus_strap;
  assign pins_raw[mba_pkg::PIN_ANY_STRAP]    = surrender_to_any_strap;
  assign pins_raw[mba_pkg::PIN_HOLD_N]       = shared_request_hold_n;
  assign pins_raw[mba_pkg::PIN_LOCK_N]       = lock_n;
  assign pins_raw[mba_pkg::PIN_CYCLE]        = proc_cycle_active;

  // processor status and all bus lines enter through two flops
  mba_sync #(
    .WIDTH    (mba_pkg::PIN_COUNT),
    .IDLE_LVL (mba_pkg::PIN_IDLE)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pins_raw),
    .sync_out (pins)
  );

  logic bclk_prev;
  logic next_bclk_prev;
  logic bclk_fall;

  logic in_init;
  logic prio_have;
  logic busy_seen;
  logic shared_req;
  logic local_mode;
  logic select_sys;
  logic any_strap;
  logic hold_act;
  logic lock_act;
  logic cycle_act;

  always_comb begin
    in_init    = !pins[mba_pkg::PIN_INIT_N];
    prio_have  = !pins[mba_pkg::PIN_PRIORITY_N];
    busy_seen  = !pins[mba_pkg::PIN_BUSY_N];
    shared_req = !pins[mba_pkg::PIN_SHARED_REQ_N];
    local_mode = pins[mba_pkg::PIN_LOCAL_STRAP];
    select_sys = pins[mba_pkg::PIN_SELECT];
    any_strap  = pins[mba_pkg::PIN_ANY_STRAP];
    hold_act   = !pins[mba_pkg::PIN_HOLD_N];
    lock_act   = !pins[mba_pkg::PIN_LOCK_N];
    cycle_act  = pins[mba_pkg::PIN_CYCLE];
  end

  // every bus-side state change except init waits for a falling bus clock edge
  always_comb begin
    next_bclk_prev = pins[mba_pkg::PIN_BUS_CLK];
    bclk_fall      = bclk_prev && !pins[mba_pkg::PIN_BUS_CLK];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bclk_prev <= 1'b0;
    end else begin
      bclk_prev <= next_bclk_prev;
    end
  end

  // control register
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;

  mba_pkg::mba_state_t state;
  mba_pkg::mba_state_t next_state;
  logic [15:0]         grants;
  logic [15:0]         next_grants;
  logic                want;
  logic                surrender;

  always_comb begin
    // strap low leaves select unread; glitches only move the request
    if (local_mode) begin
      want = cycle_act && select_sys;
    end else begin
      want = cycle_act;
    end
    if (ctrl[mba_pkg::CTRL_SW_REQUEST]) begin
      want = 1'b1;
    end
  end

  // surrender only between transfer cycles and never under lock
  always_comb begin
    surrender = 1'b0;
    if (!lock_act && !cycle_act) begin
      if (!prio_have) begin
        surrender = 1'b1;
      end
      if (local_mode && !select_sys) begin
        surrender = 1'b1;
      end
      if (shared_req && !hold_act && (any_strap || !want)) begin
        surrender = 1'b1;
      end
    end
    if (ctrl[mba_pkg::CTRL_HOLD_OFF] && !cycle_act && !lock_act) begin
      surrender = 1'b1;
    end
  end

  always_comb begin
    next_state  = state;
    next_grants = grants;
    if (in_init) begin
      next_state = mba_pkg::MBA_IDLE;
    end else if (bclk_fall) begin
      case (state)
        mba_pkg::MBA_IDLE: begin
          if (want && !ctrl[mba_pkg::CTRL_HOLD_OFF]) begin
            next_state = mba_pkg::MBA_WAIT;
          end
        end
        mba_pkg::MBA_WAIT: begin
          if (!want || ctrl[mba_pkg::CTRL_HOLD_OFF]) begin
            next_state = mba_pkg::MBA_IDLE;
          end else if (prio_have && !busy_seen) begin
            next_state  = mba_pkg::MBA_OWN;
            next_grants = grants + 16'h0001;
          end
        end
        mba_pkg::MBA_OWN: begin
          if (surrender) begin
            next_state = mba_pkg::MBA_IDLE;
          end
        end
        default: begin
          next_state = mba_pkg::MBA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state  <= mba_pkg::MBA_IDLE;
      grants <= mba_pkg::GRANTS_RESET;
    end else begin
      state  <= next_state;
      grants <= next_grants;
    end
  end

  // pin drivers, registered on aclk from next state; priority out also follows priority in, three aclk edges later
  logic next_req_n;
  logic next_prio_out_n;
  logic next_busy_oe_n;
  logic next_shared_oe_n;
  logic next_float;

  always_comb begin
    next_req_n       = !(next_state != mba_pkg::MBA_IDLE);
    next_busy_oe_n   = !(next_state == mba_pkg::MBA_OWN);
    next_shared_oe_n = !(next_state == mba_pkg::MBA_WAIT);
    next_prio_out_n  = !((next_state == mba_pkg::MBA_IDLE) && prio_have);
    next_float       = next_state != mba_pkg::MBA_OWN;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arb_request_out_n          <= 1'b1;
      busy_n_oe_n                <= 1'b1;
      shared_request_line_n_oe_n <= 1'b1;
      priority_out_n             <= 1'b1;
      bus_driver_float           <= 1'b1;
    end else begin
      arb_request_out_n          <= next_req_n;
      busy_n_oe_n                <= next_busy_oe_n;
      shared_request_line_n_oe_n <= next_shared_oe_n;
      priority_out_n             <= next_prio_out_n;
      bus_driver_float           <= next_float;
    end
  end

  // wired lines only ever pull low
  assign busy_n_o                = 1'b0;
  assign shared_request_line_n_o = 1'b0;

  // axi4-lite slave: address and data may arrive in either order
  logic                           aw_got;
  logic                           w_got;
  logic [mba_pkg::ADDR_WIDTH-1:0] aw_addr;
  logic [mba_pkg::DATA_WIDTH-1:0] w_data;
  logic [3:0]                     w_strb;
  logic                           next_aw_got;
  logic                           next_w_got;
  logic [mba_pkg::ADDR_WIDTH-1:0] next_aw_addr;
  logic [mba_pkg::DATA_WIDTH-1:0] next_w_data;
  logic [3:0]                     next_w_strb;
  logic                           next_bvalid;
  logic [1:0]                     next_bresp;

  always_comb begin
    s_axi_awready = !aw_got && !s_axi_bvalid;
    s_axi_wready  = !w_got && !s_axi_bvalid;
    next_aw_got   = aw_got;
    next_w_got    = w_got;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    next_ctrl     = ctrl;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got  = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got  = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (aw_got && w_got) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = mba_pkg::RESP_SLVERR;
      case (aw_addr)
        mba_pkg::CTRL_OFFSET: begin
          next_bresp = mba_pkg::RESP_OKAY;
          if (w_strb[0]) begin
            next_ctrl = w_data[1:0];
          end
        end
        mba_pkg::STATUS_OFFSET, mba_pkg::GRANTS_OFFSET: begin
          next_bresp = mba_pkg::RESP_OKAY;
        end
        default: begin
          next_bresp = mba_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mba_pkg::RESP_OKAY;
      ctrl         <= mba_pkg::CTRL_RESET;
    end else begin
      aw_got       <= next_aw_got;
      w_got        <= next_w_got;
      aw_addr      <= next_aw_addr;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      ctrl         <= next_ctrl;
    end
  end

  logic [mba_pkg::STAT_WIDTH-1:0] status;
  logic [mba_pkg::DATA_WIDTH-1:0] next_rdata;
  logic [1:0]                     next_rresp;
  logic                           next_rvalid;

  always_comb begin
    status                            = '0;
    status[mba_pkg::STAT_OWNS]        = state == mba_pkg::MBA_OWN;
    status[mba_pkg::STAT_REQUESTING]  = state != mba_pkg::MBA_IDLE;
    status[mba_pkg::STAT_BUSY]        = busy_seen;
    status[mba_pkg::STAT_PRIORITY]    = prio_have;
    status[mba_pkg::STAT_SHARED_REQ]  = shared_req;
    status[mba_pkg::STAT_INIT]        = in_init;
    s_axi_arready = !s_axi_rvalid;
    next_rdata    = s_axi_rdata;
    next_rresp    = s_axi_rresp;
    next_rvalid   = s_axi_rvalid;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mba_pkg::RESP_OKAY;
      next_rdata  = '0;
      case (s_axi_araddr)
        mba_pkg::CTRL_OFFSET:   next_rdata[1:0] = ctrl;
        mba_pkg::STATUS_OFFSET: next_rdata[mba_pkg::STAT_WIDTH-1:0] = status;
        mba_pkg::GRANTS_OFFSET: next_rdata[15:0] = grants;
        default: begin
          next_rresp = mba_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= mba_pkg::RESP_OKAY;
      s_axi_rdata  <= '0;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
    end
  end

endmodule

// ===== testbench/mba_arbiter_asserts.sv
`timescale 1ns/10ps
module mba_arbiter_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic init_n,
  input wire logic lock_n,
  input wire logic priority_in_n,
  input wire logic priority_out_n,
  input wire logic arb_request_out_n,
  input wire logic busy_n_oe_n,
  input wire logic shared_request_line_n_oe_n,
  input wire logic bus_driver_float,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_float; bus_driver_float == busy_n_oe_n; endproperty
  a_float: assert property (p_float) else $error("drivers enabled without holding busy");
  property p_owner_quiet; !bus_driver_float |-> shared_request_line_n_oe_n; endproperty
  a_owner_quiet: assert property (p_owner_quiet) else $error("owner pulls common request");
  property p_owner_req; !bus_driver_float |-> !arb_request_out_n; endproperty
  a_owner_req: assert property (p_owner_req) else $error("owner without request");
  property p_shared_wait; !shared_request_line_n_oe_n |-> !arb_request_out_n && bus_driver_float; endproperty
  a_shared_wait: assert property (p_shared_wait) else $error("common request pulled while not waiting");
  property p_prio_out; !priority_out_n |-> arb_request_out_n && bus_driver_float; endproperty
  a_prio_out: assert property (p_prio_out) else $error("priority passed on while busy");
  property p_init; !init_n [*6] |-> bus_driver_float && arb_request_out_n; endproperty
  a_init: assert property (p_init) else $error("ownership kept under init");
  property p_lock; (!lock_n [*5]) ##0 !bus_driver_float |=> !bus_driver_float; endproperty
  a_lock: assert property (p_lock) else $error("bus given up while locked");
  property p_seize; $fell(busy_n_oe_n) |-> $past(!arb_request_out_n); endproperty
  a_seize: assert property (p_seize) else $error("bus seized without request");
  property p_grant; $fell(busy_n_oe_n) |-> !$past(priority_in_n, 3); endproperty
  a_grant: assert property (p_grant) else $error("bus seized without priority");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  c_own: cover property ($fell(bus_driver_float));
  c_release: cover property ($rose(bus_driver_float));
  c_pass: cover property ($fell(priority_out_n));
endmodule
bind mba_arbiter mba_arbiter_asserts i_mba_arbiter_asserts (
  .aclk(aclk), .aresetn(aresetn), .init_n(init_n), .lock_n(lock_n), .priority_in_n(priority_in_n),
  .priority_out_n(priority_out_n), .arb_request_out_n(arb_request_out_n), .busy_n_oe_n(busy_n_oe_n),
  .shared_request_line_n_oe_n(shared_request_line_n_oe_n), .bus_driver_float(bus_driver_float),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);

// ===== testbench/mba_peer_model.sv
`timescale 1ns/10ps
module mba_peer_model (
  input  wire logic peer_want,
  input  wire logic low_want,
  input  wire logic busy_n,
  output logic      bus_clk,
  output logic      priority_in_n,
  output logic      busy_pull = 1'b0,
  output logic      shared_pull
);
  // free-running bus clock, offset so its edges never meet aclk edges
  initial begin
    bus_clk = 1'b0;
    #3.3;
    forever #62.5 bus_clk = ~bus_clk;
  end
  // the peer outranks the block: priority is taken away whenever it asks
  assign priority_in_n = peer_want;
  // seize only once busy is free, keep it while wanted
  always @(negedge bus_clk) busy_pull <= peer_want & (busy_pull | busy_n);
  // a waiting peer or a lower-priority requester pulls the wired request
  assign shared_pull = (peer_want & ~busy_pull) | low_want;
endmodule

// ===== testbench/mba_arbiter_tb_top.sv
`timescale 1ns/10ps
module mba_arbiter_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        bus_clk, priority_in_n, priority_out_n, arb_request_out_n, bus_driver_float;
  logic        busy_n_o, busy_n_oe_n, shared_request_line_n_o, shared_request_line_n_oe_n;
  logic        init_n = 1'b1, system_or_local_select = 1'b0, local_bus_strap = 1'b0;
  logic        surrender_to_any_strap = 1'b0, shared_request_hold_n = 1'b1, lock_n = 1'b1;
  logic        proc_cycle_active = 1'b0, peer_want = 1'b0, low_want = 1'b0, busy_pull, shared_pull;
  wire logic   busy_w = ~busy_pull & (busy_n_oe_n | busy_n_o);
  wire logic   shared_w = ~shared_pull & (shared_request_line_n_oe_n | shared_request_line_n_o);
  int          err_count = 0;
  int          checks = 0;
  always #5 aclk = ~aclk;
  mba_arbiter i_mba_arbiter (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .bus_clk, .init_n, .priority_in_n, .priority_out_n, .arb_request_out_n,
    .busy_n_i(busy_w), .busy_n_o, .busy_n_oe_n, .shared_request_line_n_i(shared_w), .shared_request_line_n_o,
    .shared_request_line_n_oe_n, .system_or_local_select, .local_bus_strap, .surrender_to_any_strap,
    .shared_request_hold_n, .lock_n, .proc_cycle_active, .bus_driver_float
  );
  mba_peer_model i_mba_peer_model (
    .peer_want, .low_want, .busy_n(busy_w), .bus_clk, .priority_in_n, .busy_pull, .shared_pull
  );
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d comparisons", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic pin(input int s);
    return (s == 0) ? bus_driver_float : (s == 1) ? arb_request_out_n : priority_out_n;
  endfunction
  // stay: pin must keep v for 60 cycles; otherwise it must reach v within 400
  task automatic watch(input string name, input int s, input logic v, input bit stay);
    int   n;
    logic ok;
    ok = 1'b1;
    for (n = 0; n < (stay ? 60 : 400); n++) begin
      @(negedge aclk);
      if (stay && pin(s) !== v) ok = 1'b0;
      if (!stay && pin(s) === v) break;
    end
    if (pin(s) !== v) ok = 1'b0;
    check(name, ok, 1'b1);
    if (!ok && !stay) tally_and_finish;
  endtask
  task automatic axi(input bit wr, input logic [3:0] a, input logic [31:0] d);
    int   n;
    logic ta, tw, tr;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    tr = 1'b0;
    for (n = 0; n < 50 && !tr; n++) begin
      @(negedge aclk);
      ta = wr ? (s_axi_awvalid & s_axi_awready) : (s_axi_arvalid & s_axi_arready);
      tw = s_axi_wvalid & s_axi_wready;
      tr = wr ? s_axi_bvalid : s_axi_rvalid;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (ta && wr) s_axi_awvalid <= 1'b0;
      if (ta && !wr) s_axi_arvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr && wr) s_axi_bready <= 1'b0;
      if (tr && !wr) s_axi_rready <= 1'b0;
    end
    check("bus answer", tr, 1'b1);
    if (tr !== 1'b1) tally_and_finish;
  endtask
  task automatic t_regs;
    axi(0, mba_pkg::GRANTS_OFFSET, 32'h0);
    check("grants reset", rd[15:0], mba_pkg::GRANTS_RESET);
    axi(1, 4'hC, 32'h1);
    check("unmapped write", rs, mba_pkg::RESP_SLVERR);
    axi(0, 4'hC, 32'h0);
    check("unmapped read", rs, mba_pkg::RESP_SLVERR);
    axi(1, mba_pkg::CTRL_OFFSET, 32'hFFFF_FFFE);
    check("ctrl write response", rs, mba_pkg::RESP_OKAY);
    axi(0, mba_pkg::CTRL_OFFSET, 32'h0);
    check("ctrl readback", rd[1:0], 2'h2);
    proc_cycle_active <= 1'b1;
    watch("hold-off blocks request", 1, 1'b1, 1);
    axi(1, mba_pkg::CTRL_OFFSET, 32'h0);
  endtask
  task automatic t_acquire;
    watch("request driven low", 1, 1'b0, 0);
    check("common request while waiting", shared_request_line_n_oe_n, 1'b0);
    watch("bus owned", 0, 1'b0, 0);
    check("busy held", busy_n_oe_n, 1'b0);
    check("owner leaves common request", shared_request_line_n_oe_n, 1'b1);
    axi(0, mba_pkg::GRANTS_OFFSET, 32'h0);
    check("grant counted", rd[15:0], 16'h0001);
    axi(0, mba_pkg::STATUS_OFFSET, 32'h0);
    check("status while owning", rd[5:0], 6'h0F);
  endtask
  task automatic t_lock;
    @(posedge aclk);
    lock_n <= 1'b0;
    peer_want <= 1'b1;
    proc_cycle_active <= 1'b0;
    watch("lock keeps bus", 0, 1'b0, 1);
    @(posedge aclk);
    lock_n <= 1'b1;
    watch("lost priority surrenders", 0, 1'b1, 0);
    check("request released", arb_request_out_n, 1'b1);
    @(posedge aclk);
    peer_want <= 1'b0;
  endtask
  task automatic t_any;
    axi(1, mba_pkg::CTRL_OFFSET, 32'h1);
    watch("software request owns", 0, 1'b0, 0);
    @(posedge aclk);
    shared_request_hold_n <= 1'b0;
    surrender_to_any_strap <= 1'b1;
    low_want <= 1'b1;
    watch("hold keeps bus", 0, 1'b0, 1);
    @(posedge aclk);
    shared_request_hold_n <= 1'b1;
    watch("common request surrenders", 0, 1'b1, 0);
    watch("owns again", 0, 1'b0, 0);
    watch("surrenders again", 0, 1'b1, 0);
    axi(1, mba_pkg::CTRL_OFFSET, 32'h0);
    watch("request dropped", 1, 1'b1, 0);
    @(posedge aclk);
    low_want <= 1'b0;
    surrender_to_any_strap <= 1'b0;
  endtask
  // select is only changed on aclk edges, so it never glitches
  task automatic t_local;
    @(posedge aclk);
    local_bus_strap <= 1'b1;
    proc_cycle_active <= 1'b1;
    watch("select low no request", 1, 1'b1, 1);
    @(posedge aclk);
    system_or_local_select <= 1'b1;
    watch("select high owns", 0, 1'b0, 0);
    @(posedge aclk);
    system_or_local_select <= 1'b0;
    proc_cycle_active <= 1'b0;
    watch("select low surrenders", 0, 1'b1, 0);
    @(posedge aclk);
    local_bus_strap <= 1'b0;
    proc_cycle_active <= 1'b1;
    watch("select ignored", 0, 1'b0, 0);
  endtask
  task automatic t_init;
    @(posedge aclk);
    init_n <= 1'b0;
    watch("init frees bus", 0, 1'b1, 0);
    check("init drops request", arb_request_out_n, 1'b1);
    @(posedge aclk);
    init_n <= 1'b1;
    proc_cycle_active <= 1'b0;
  endtask
  task automatic t_prio_out;
    watch("priority passed on", 2, 1'b0, 0);
    @(posedge aclk);
    peer_want <= 1'b1;
    watch("no priority to pass", 2, 1'b1, 0);
    @(posedge aclk);
    peer_want <= 1'b0;
    watch("priority back", 2, 1'b0, 0);
    @(posedge aclk);
    proc_cycle_active <= 1'b1;
    watch("requester keeps priority", 2, 1'b1, 0);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("float after reset", bus_driver_float, 1'b1);
    check("request after reset", arb_request_out_n, 1'b1);
    t_regs;
    t_acquire;
    t_lock;
    t_any;
    t_local;
    t_init;
    t_prio_out;
    tally_and_finish;
  end
endmodule
